// ===== rtl/card_line_regs.svh
// Constants for the card bus line control block
`ifndef CARD_LINE_REGS_SVH
`define CARD_LINE_REGS_SVH
`define DATA_LINE_COUNT    8
`define CLK_PERIOD_NS      50
`define MAX_CLK_STD_MHZ    26
`define MAX_CLK_HS_MHZ     52
`define MAX_CLK_LEGACY_MHZ 20
`define CMD_FRAME_BITS     8'd48
`define CMD_ARG_MSB        39
`define CMD_ARG_LSB        8
`define SECTOR_SHIFT       9
`define PULLUP_ALL         8'hfe
`define PULLUP_W4          8'hf0
`define PULLUP_W8          8'h00
`define LANE_MASK_W1       8'h01
`define LANE_MASK_W4       8'h0f
`define LANE_MASK_W8       8'hff
`define BIT_CNT_ZERO       8'h00
`define BIT_CNT_ONE        8'h01
`define SYNC_IDLE          10'h3ff
`endif

// ===== rtl/card_line_pkg.sv
// Types shared by the card bus line control block
package card_line_pkg;
  typedef enum logic [1:0] {WIDTH_1, WIDTH_4, WIDTH_8} bus_width_t;
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } data_drive_t;
  typedef struct packed {
    logic out;
    logic oe;
  } cmd_drive_t;
endpackage

// ===== rtl/link_sampler.sv
// Two-flop synchroniser and edge finder for the host bus clock and lines
`timescale 1ns/1ps
`include "card_line_regs.svh"
module link_sampler (
  input  wire logic       core_clk,   // Block clock
  input  wire logic       srst,       // Synchronous reset
  input  wire logic [9:0] rawIn,      // Clock, command, data pins
  output logic      [9:0] syncOut,    // Synchronised pins
  output logic            clkRise,    // Bus clock rising edge
  output logic            clkFall     // Bus clock falling edge
);
  logic [9:0] meta_q;
  logic [9:0] sync_q;
  logic       clkLast_q;

  // First stage is read only by the second; reset to the idle-high level
  // so that the flush after reset shows no false bus clock rise
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta_q    <= `SYNC_IDLE;
      sync_q    <= `SYNC_IDLE;
      clkLast_q <= 1'b1;
    end else begin
      meta_q    <= rawIn;
      sync_q    <= meta_q;
      clkLast_q <= sync_q[0];
    end
  end

  assign syncOut = sync_q;
  assign clkRise = sync_q[0] & ~clkLast_q;
  assign clkFall = ~sync_q[0] & clkLast_q;
endmodule // link_sampler

// ===== rtl/card_bus_line_control.sv
// Card side line control: command/data pin drive, width, pull-ups, addressing
`timescale 1ns/1ps
`include "card_line_regs.svh"

// What this block does
// - One bit per clock on command, each data line
// - Works only with bus clocks under half the 20 MHz block clock, even stopped
// - Command open-drain in init, push-pull after
// - Commands arrive on command line, responses leave
// - Data push-pull, only one side drives
// - After reset, data on line zero only
// - Upper data line pull-ups on in single width
// - Four-line width drops pull-ups on lines 1-3
// - Eight-line width drops pull-ups on 1-7
// - Large cards take sector index addresses
// - Address argument is 32 bits wide
// - Supports 1/4/8 widths; 26 and 52 MHz bus clocks are too fast to sample
// - A 20 MHz legacy host bus clock is too fast to sample
// - Initialization uses command line only
module card_bus_line_control
  import card_line_pkg::*;
(
  input  wire logic                    core_clk,      // Block clock, 20 MHz
  input  wire logic                    srst,          // Synchronous reset
  input  wire logic                    busClkIn,      // Host bus clock pin
  input  wire logic                    cmdIn,         // Command pin level
  input  wire logic [7:0]              dataIn,        // Data pin levels
  output card_line_pkg::cmd_drive_t    cmdDrive,      // Command out and enable
  output card_line_pkg::data_drive_t   dataDrive,     // Data out and enables
  output logic      [7:0]              pullupEn,      // Internal pull-up on
  input  wire logic                    initDone,      // Init phase finished
  input  wire logic                    highCapacity,  // Card above 2 GB
  input  wire logic                    setWidth,      // Apply new width
  input  wire card_line_pkg::bus_width_t newWidth,    // Width requested
  input  wire logic                    rspStart,      // Start response
  input  wire logic [47:0]             rspFrame,      // Response bits
  input  wire logic                    txStart,       // Start data send
  input  wire logic [7:0]              txBits,        // Bits per data clock
  input  wire logic                    txLast,        // Last data beat
  output logic      [47:0]             cmdFrame,      // Received command
  output logic                         cmdValid,      // Command pulse
  output logic      [31:0]             blockAddr,     // Address in sectors
  output card_line_pkg::bus_width_t    widthNow,      // Active width
  output logic      [7:0]              rxBits,        // Data beat received
  output logic                         rxValid,       // Data beat pulse
  output logic                         txReady        // Next beat accepted
);
  import card_line_pkg::*;

  typedef enum logic [1:0] {ST_IDLE, ST_CMD_RX, ST_RSP_TX, ST_DATA_TX} st_t;

  logic [9:0]  syncPins;
  logic        clkRise;
  logic        clkFall;
  st_t         state_q, state_d;
  bus_width_t  width_q;
  logic [7:0]  bitCnt_q;
  logic [47:0] shift_q;
  logic        initMode_q;
  cmd_drive_t  cmdDrive_q;
  data_drive_t dataDrive_q;
  logic [7:0]  pullup_q;
  logic [47:0] cmdFrame_q;
  logic        cmdValid_q;
  logic [31:0] blockAddr_q;
  logic [7:0]  rxBits_q;
  logic        rxValid_q;
  logic        txReady_q;
  logic        dataBusy_q;

  // Bus clock is only sampled, so no edge means no progress
  link_sampler u_sampler (
    .core_clk (core_clk),
    .srst     (srst),
    .rawIn    ({dataIn, cmdIn, busClkIn}),
    .syncOut  (syncPins),
    .clkRise  (clkRise),
    .clkFall  (clkFall)
  );

  wire        cmdPin   = syncPins[1];
  wire [7:0]  dataPins = syncPins[9:2];
  // Active lanes follow the width; wider is host choice
  wire [7:0]  laneMask = (width_q == WIDTH_8) ? `LANE_MASK_W8 :
                         (width_q == WIDTH_4) ? `LANE_MASK_W4 :
                                                `LANE_MASK_W1;
  // Pull-up pattern on width change
  wire [7:0]  pullNext = (newWidth == WIDTH_8) ? `PULLUP_W8 :
                         (newWidth == WIDTH_4) ? `PULLUP_W4 :
                                                 `PULLUP_ALL;
  // Our own held response bit must not look like a host start bit
  wire        cmdStart = (state_q == ST_IDLE) & clkRise & ~cmdPin &
                         ~cmdDrive_q.oe;
  wire        frameEnd = (bitCnt_q == `CMD_FRAME_BITS - `BIT_CNT_ONE);
  // 32-bit argument; byte form shifted to sectors for small cards
  wire [31:0] argField = shift_q[`CMD_ARG_MSB-1:`CMD_ARG_LSB-1];
  wire [31:0] argAddr  = highCapacity ? argField :
                         (argField >> `SECTOR_SHIFT);
  // Data is never used before init ends; refused unless idle
  wire        dataGo   = txStart & initDone & ~dataBusy_q &
                         (state_q == ST_IDLE) & ~cmdStart & ~rspStart;

  // Frame sequencer: one bit per bus clock edge
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (cmdStart) state_d = ST_CMD_RX;
        else if (rspStart) state_d = ST_RSP_TX;
        else if (dataGo) state_d = ST_DATA_TX;
      end
      ST_CMD_RX:  if (clkRise && frameEnd) state_d = ST_IDLE;
      ST_RSP_TX:  if (clkFall && frameEnd) state_d = ST_IDLE;
      ST_DATA_TX: if (clkFall && txLast) state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end

  // Command receive and response shift
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_q  <= ST_IDLE;
      bitCnt_q <= `BIT_CNT_ZERO;
      shift_q  <= 48'h0;
    end else begin
      state_q <= state_d;
      if (cmdStart) begin
        bitCnt_q <= `BIT_CNT_ONE;
        shift_q  <= 48'h0;
      end else if (state_q == ST_CMD_RX && clkRise) begin
        bitCnt_q <= bitCnt_q + `BIT_CNT_ONE;
        shift_q  <= {shift_q[46:0], cmdPin};
      end else if (state_q == ST_IDLE && rspStart) begin
        bitCnt_q <= `BIT_CNT_ZERO;
        shift_q  <= rspFrame;
      end else if (state_q == ST_RSP_TX && clkFall) begin
        bitCnt_q <= bitCnt_q + `BIT_CNT_ONE;
        shift_q  <= {shift_q[46:0], 1'b1};
      end
    end
  end

  // Command pin drive: open-drain only pulls low during init
  always_ff @(posedge core_clk) begin
    if (srst) begin
      initMode_q <= 1'b1;
      cmdDrive_q <= '{out: 1'b1, oe: 1'b0};
    end else begin
      if (initDone) initMode_q <= 1'b0;
      if (state_q == ST_RSP_TX && clkFall) begin
        cmdDrive_q.out <= shift_q[47];
        cmdDrive_q.oe  <= initMode_q ? ~shift_q[47] : 1'b1;
      end else if (state_q != ST_RSP_TX && clkFall) begin
        // Last bit stands for its whole bus clock, let go at next fall
        cmdDrive_q <= '{out: 1'b1, oe: 1'b0};
      end
    end
  end

  // Received command out, with sector address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cmdFrame_q  <= 48'h0;
      cmdValid_q  <= 1'b0;
      blockAddr_q <= 32'h0;
    end else begin
      cmdValid_q <= 1'b0;
      if (state_q == ST_CMD_RX && clkRise && frameEnd) begin
        cmdFrame_q  <= {shift_q[46:0], cmdPin};
        cmdValid_q  <= 1'b1;
        blockAddr_q <= argAddr;
      end
    end
  end

  // Width and pull-ups change in the same cycle
  always_ff @(posedge core_clk) begin
    if (srst) begin
      width_q  <= WIDTH_1;
      pullup_q <= `PULLUP_ALL;
    end else if (setWidth && state_q == ST_IDLE) begin
      width_q  <= newWidth;
      pullup_q <= pullNext;
    end
  end

  // Data drive: card owns lines only while sending
  always_ff @(posedge core_clk) begin
    if (srst) begin
      dataDrive_q <= '{out: 8'h00, oe: 8'h00};
      dataBusy_q  <= 1'b0;
      txReady_q   <= 1'b0;
    end else begin
      txReady_q <= 1'b0;
      if (dataGo) dataBusy_q <= 1'b1;
      if (state_q == ST_DATA_TX && clkFall) begin
        dataDrive_q.out <= txBits & laneMask;
        dataDrive_q.oe  <= laneMask;
        txReady_q       <= 1'b1;
        if (txLast) dataBusy_q <= 1'b0;
      end else if (state_q != ST_DATA_TX && (clkFall || setWidth)) begin
        // Last beat held to next fall; a width change lets go at once
        dataDrive_q <= '{out: 8'h00, oe: 8'h00};
      end
    end
  end

  // Host data beats sampled on active lanes only
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rxBits_q  <= 8'h00;
      rxValid_q <= 1'b0;
    end else begin
      rxValid_q <= clkRise & initDone & (state_q == ST_IDLE);
      if (clkRise) rxBits_q <= dataPins & laneMask;
    end
  end

  assign cmdDrive  = cmdDrive_q;
  assign dataDrive = dataDrive_q;
  assign pullupEn  = pullup_q;
  assign cmdFrame  = cmdFrame_q;
  assign cmdValid  = cmdValid_q;
  assign blockAddr = blockAddr_q;
  assign widthNow  = width_q;
  assign rxBits    = rxBits_q;
  assign rxValid   = rxValid_q;
  assign txReady   = txReady_q;
endmodule // card_bus_line_control

// ===== verif/card_bus_line_control_props.sv
// Checker for the card bus line control ports
`timescale 1ns/1ps
module card_line_props
  import card_line_pkg::*;
(
  input wire logic                  core_clk,  // Block clock
  input wire logic                  srst,      // Sync reset
  input wire logic                  initDone,  // Init over
  input wire logic                  highCapacity, // Sector addressing
  input wire logic                  setWidth,  // Width request
  input card_line_pkg::cmd_drive_t  cmdDrive,  // Command drive
  input card_line_pkg::data_drive_t dataDrive, // Data drive
  input wire logic [7:0]            pullupEn,  // Pull-ups
  input wire logic [47:0]           cmdFrame,  // Command frame
  input wire logic                  cmdValid,  // Command pulse
  input wire logic [31:0]           blockAddr, // Sector address
  input wire logic [7:0]            rxBits,    // Data beat received
  input wire logic                  rxValid,   // Data beat pulse
  input card_line_pkg::bus_width_t  widthNow   // Active width
);
  // Lanes the active width may drive
  wire [7:0] laneMask = widthNow == WIDTH_8 ? 8'hff :
                        widthNow == WIDTH_4 ? 8'h0f : 8'h01;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  property p_pullW1; widthNow == WIDTH_1 |-> pullupEn == 8'hfe; endproperty
  a_pullW1: assert property (p_pullW1) else $error("x1 pull-ups");
  property p_pullW4; widthNow == WIDTH_4 |-> pullupEn == 8'hf0; endproperty
  a_pullW4: assert property (p_pullW4) else $error("x4 pull-ups");
  property p_pullW8; widthNow == WIDTH_8 |-> pullupEn == 8'h00; endproperty
  a_pullW8: assert property (p_pullW8) else $error("x8 pull-ups");
  property p_rstW; $past(srst) |-> widthNow == WIDTH_1; endproperty
  a_rstW: assert property (p_rstW) else $error("width after reset");
  // Width moves only on request; reset edges excused
  property p_wChg; $changed(widthNow) |-> $past(setWidth) || $past(srst);
  endproperty
  a_wChg: assert property (p_wChg) else $error("width moved");
  property p_lanes; (dataDrive.oe & ~laneMask) == 8'h00; endproperty
  a_lanes: assert property (p_lanes) else $error("lane outside width");
  property p_rxLanes; rxValid |-> (rxBits & ~laneMask) == 8'h00; endproperty
  a_rxLanes: assert property (p_rxLanes) else $error("rx lane");
  property p_cmdOd; !initDone && cmdDrive.oe |-> !cmdDrive.out; endproperty
  a_cmdOd: assert property (p_cmdOd) else $error("cmd high in init");
  property p_noDat; !initDone |-> dataDrive.oe == 8'h00; endproperty
  a_noDat: assert property (p_noDat) else $error("data in init");
  property p_addr; cmdValid |-> blockAddr == (highCapacity ?
    cmdFrame[39:8] : {9'h000, cmdFrame[39:17]}); endproperty
  a_addr: assert property (p_addr) else $error("address");
  c_cmd: cover property (cmdValid && highCapacity);
  c_rsp: cover property (cmdDrive.oe && !initDone);
  c_dat8: cover property (dataDrive.oe == 8'hff);
endmodule // card_line_props

bind card_bus_line_control card_line_props chk_u (.core_clk(core_clk),
  .srst(srst), .initDone(initDone), .highCapacity(highCapacity),
  .setWidth(setWidth), .cmdDrive(cmdDrive), .dataDrive(dataDrive),
  .pullupEn(pullupEn), .cmdFrame(cmdFrame), .cmdValid(cmdValid),
  .blockAddr(blockAddr), .rxBits(rxBits), .rxValid(rxValid),
  .widthNow(widthNow));

// ===== verif/host_bus_model.sv
// Host side model: bus clock, command line and line resolution
`timescale 1ns/1ps
module host_bus_model
  import card_line_pkg::*;
(
  input card_line_pkg::cmd_drive_t  cmdDrive,  // Card command drive
  input card_line_pkg::data_drive_t dataDrive, // Card data drive
  input wire logic [7:0]            pullupEn,  // Card pull-ups
  output logic                      busClk,    // Idles high
  output logic                      cmdLine,   // Command level
  output logic [7:0]                dataLine   // Data levels
);
  logic       hostCmd = 1'b1;
  logic       toggle = 1'b0;
  logic [8:0] tookVal;
  event       took;
  initial busClk = 1'b1;
  // A released command line floats up; open-drain only pulls low
  assign cmdLine = cmdDrive.oe ? cmdDrive.out : hostCmd;
  // Unpulled idle lines wander so stale values never pass
  assign dataLine = (dataDrive.oe & dataDrive.out) |
                    (~dataDrive.oe & (pullupEn | {8{toggle}}));
  // One bit per 400 ns clock, sampled at the end of each cycle
  task automatic run(input logic [47:0] cmd, input int n,
                     input bit drv, input bit watch);
    for (int k = n - 1; k >= 0; k--) begin
      busClk = 1'b0;
      hostCmd = drv ? cmd[k] : 1'b1;
      toggle = ~toggle;
      #200 busClk = 1'b1;
      #199 tookVal = {cmdLine, dataLine};
      if (watch)
        -> took;
      #1;
    end
    hostCmd = 1'b1;
  endtask
endmodule // host_bus_model

// ===== verif/test_card_bus_line_control.sv
// Self-checking bench for the card bus line control block
`timescale 1ns/1ps
module test_card_bus_line_control;
  import card_line_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, initDone = 1'b0;
  logic highCapacity = 1'b0, setWidth = 1'b0, rspStart = 1'b0;
  logic txStart = 1'b0, txLast = 1'b0, busClk, cmdLine, cmdValid, txReady;
  logic [47:0] rspFrame = 48'h0, cmdFrame;
  logic [7:0] txBits = 8'h00, pullupEn, dataLine;
  logic [31:0] blockAddr, arg, qA[$];
  logic [17:0] m, qB[$];
  bus_width_t newWidth = WIDTH_1, widthNow;
  cmd_drive_t cmdDrive;
  data_drive_t dataDrive;
  int n_fail = 0, checked = 0, seed = 74990;
  always #25 core_clk = ~core_clk;
  card_bus_line_control dut_u (.core_clk(core_clk), .srst(srst),
    .busClkIn(busClk), .cmdIn(cmdLine), .dataIn(dataLine),
    .cmdDrive(cmdDrive), .dataDrive(dataDrive), .pullupEn(pullupEn),
    .initDone(initDone), .highCapacity(highCapacity), .setWidth(setWidth),
    .newWidth(newWidth), .rspStart(rspStart), .rspFrame(rspFrame),
    .txStart(txStart), .txBits(txBits), .txLast(txLast),
    .cmdFrame(cmdFrame), .cmdValid(cmdValid), .blockAddr(blockAddr),
    .widthNow(widthNow), .rxBits(), .rxValid(), .txReady(txReady));
  host_bus_model host_u (.cmdDrive(cmdDrive), .dataDrive(dataDrive),
    .pullupEn(pullupEn), .busClk(busClk), .cmdLine(cmdLine),
    .dataLine(dataLine));
  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: exp %h got %h", $time, exp, got);
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Watchers take the oldest note whenever a result shows
  always @(negedge core_clk) if (cmdValid === 1'b1) begin
    chk(qA.pop_front(), blockAddr);
    chk(qA.pop_front(), cmdFrame[39:8]);
  end
  always @(host_u.took) begin
    m = qB.pop_front();
    chk({23'h0, m[8:0]}, {23'h0, host_u.tookVal & m[17:9]});
  end
  // Bounded wait for the card to take a data beat
  task automatic waitReady;
    int i;
    for (i = 0; i < 300 && txReady !== 1'b1; i++) @(negedge core_clk);
    if (i == 300) begin
      n_fail++;
      summarize();
    end
  endtask
  task automatic cmd(input logic hc);
    arg = $random(seed);
    highCapacity = hc; // Host learned capacity elsewhere
    qA.push_back(hc ? arg : arg >> 9);
    qA.push_back(arg);
    host_u.run({2'b01, 6'h11, arg, 8'h01}, 48, 1'b1, 1'b0);
    repeat (8) @(negedge core_clk);
  endtask
  task automatic rsp;
    rspFrame[47:16] = $random(seed);
    rspFrame[15:0] = 16'($random(seed));
    rspStart = 1'b1;
    @(negedge core_clk);
    rspStart = 1'b0;
    for (int k = 47; k >= 0; k--) qB.push_back({9'h100, rspFrame[k], 8'h00});
    host_u.run(48'h0, 48, 1'b0, 1'b1);
    repeat (8) @(negedge core_clk);
  endtask
  // Two beats at a new width; stray lanes are masked off
  task automatic tx(input bus_width_t w, input logic [7:0] k);
    newWidth = w;
    setWidth = 1'b1;
    @(negedge core_clk);
    setWidth = 1'b0;
    txBits = 8'($random(seed));
    txStart = 1'b1;
    qB.push_back({1'b0, k, 1'b0, txBits & k});
    @(negedge core_clk);
    txStart = 1'b0;
    fork
      host_u.run(48'h0, 2, 1'b0, 1'b1);
      begin
        waitReady();
        txBits = 8'($random(seed));
        txLast = 1'b1;
        qB.push_back({1'b0, k, 1'b0, txBits & k});
        @(negedge core_clk);
        waitReady();
        txLast = 1'b0;
      end
    join
    repeat (8) @(negedge core_clk);
  endtask
  initial begin
    #1000000;
    n_fail++;
    summarize();
  end
  initial begin
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    txStart = 1'b1;
    @(negedge core_clk);
    txStart = 1'b0;
    cmd(1'b0);
    rsp();
    initDone = 1'b1;
    cmd(1'b1);
    rsp();
    tx(WIDTH_4, 8'h0f);
    tx(WIDTH_1, 8'h01);
    tx(WIDTH_8, 8'hff);
    srst = 1'b1;
    repeat (8) @(negedge core_clk);
    srst = 1'b0;
    chk(32'h000000fe, {24'h0, pullupEn});
    chk({30'h0, WIDTH_1}, {30'h0, widthNow});
    chk(32'h0, 32'(qA.size() + qB.size()));
    summarize();
  end
endmodule // test_card_bus_line_control
